// ===== inc/decode_pkg.sv
/*
 * Constants, field layouts and types for the instruction decode and
 * cycle-timing block of a small 8-bit core with 14-bit instruction words.
 * Assumes one core clock per oscillator period; no software-visible registers.
 */
// How it works
// - each instruction is one 14-bit word carrying the operation code and all of its operands.
// - operation codes fall into byte-oriented, bit-oriented and literal/control classes.
// - the direct call and the call through the working register take two instruction cycles.
// - the plain return, the literal-loading return and the interrupt return take two instruction cycles.
// - jumps, relative and working-register branches, bit tests and count-and-skip take two cycles.
// - an indirect access whose selected pointer addresses program memory adds one instruction cycle.
// - every other instruction completes in one instruction cycle.
// - one instruction cycle is exactly four oscillator clock periods.
// - an instruction naming a file register reads it first, then modifies, then stores; here the bit tests read the register and store nothing.
// - destination select 0 sends the result to the working register, 1 back to the file register.
// - the file-address operand selects a register from 0x00 to 0x7F of the current data space.
// - the bit operand selects one bit position of an 8-bit file register.
// - the pointer-number operand selects pointer register 0 or 1.
// - a two-bit mode operand picks pre-increment, pre-decrement, post-increment or post-decrement.
// - don't-care bit positions decode the same whether they hold 0 or 1.
package decode_pkg;

   // ----------------------------------------------------------------
   // word layout
   // ----------------------------------------------------------------
   localparam int INSTR_W = 14;
   localparam int FILE_W = 7;
   localparam int GRP_HI = 13;
   localparam int GRP_LO = 12;
   localparam int D_BIT = 7;
   localparam int BIT_HI = 9;
   localparam int BIT_LO = 7;
   localparam int PTR_N_IND = 2;
   localparam int PTR_N_OFS = 6;
   localparam int STORE_SEL = 3;

   // ----------------------------------------------------------------
   // operation codes
   // ----------------------------------------------------------------
   localparam logic [1:0] GRP_BYTE = 2'h0;
   localparam logic [1:0] GRP_BIT = 2'h1;
   localparam logic [13:0] OP_RETURN = 14'h0008;
   localparam logic [13:0] OP_RETURN_INT = 14'h0009;
   localparam logic [13:0] OP_CALL_W = 14'h000a;
   localparam logic [13:0] OP_BRANCH_W = 14'h000b;
   localparam logic [9:0] IND_PREFIX = 10'h001;
   localparam logic [4:0] BOP_CTRL = 5'h00;
   localparam logic [3:0] BOP_CLR = 4'h1;
   localparam logic [3:0] BOP_DEC_SKIP = 4'hb;
   localparam logic [3:0] BOP_INC_SKIP = 4'hf;
   localparam logic [2:0] LOP_CALL = 3'h4;
   localparam logic [2:0] LOP_JUMP = 3'h5;
   localparam logic [5:0] LOP_RETLIT = 6'h34;
   localparam logic [4:0] LOP_BRANCH_REL = 5'h19;
   localparam logic [6:0] LOP_IND_RD = 7'h7e;
   localparam logic [6:0] LOP_IND_WR = 7'h7f;
   localparam logic [5:0] IND_FILE_HI = 6'h00;

   // ----------------------------------------------------------------
   // timing and reset values
   // ----------------------------------------------------------------
   localparam int PHASES = 4;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] PHASE_RST = 2'h0;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_EXTRA = 2'h1;
   localparam logic [1:0] CYC_RST = 2'h0;
   localparam logic [13:0] INSTR_RST = 14'h0000;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CLS_BYTE = 2'h0, CLS_BIT = 2'h1, CLS_LITCTL = 2'h2} instr_class_t;

   typedef enum logic [1:0] {PRE_INC = 2'h0, PRE_DEC = 2'h1, POST_INC = 2'h2, POST_DEC = 2'h3} ptr_mode_t;

   typedef enum logic [1:0] {SEQ_IDLE = 2'b01, SEQ_EXEC = 2'b10} seq_state_t;

   typedef struct packed {
      instr_class_t cls;
      logic file_op;
      logic file_store;
      logic w_store;
      logic [FILE_W-1:0] file_addr;
      logic [2:0] bit_sel;
      logic ptr_used;
      logic ptr_num;
      logic mode_used;
      ptr_mode_t ptr_mode;
      logic [1:0] cycles;
   } decode_t;

   typedef struct packed {
      seq_state_t seq;
      logic [1:0] phase;
      logic [1:0] cyc;
      logic [INSTR_W-1:0] instr;
      decode_t dec;
   } core_state_t;

endpackage

// ===== rtl/instr_cycle_decode.sv
/*
 * Instruction decode and cycle sequencer: takes 14-bit words from program
 * memory, decodes class and operands, and paces read-modify-write strobes
 * over four-phase instruction cycles.
 * Assumes inputs are synchronous to core_clk and that program memory holds
 * a word on instr_word whenever instr_valid is high.
 */
`timescale 1ns/100ps

module instr_cycle_decode #(
   parameter int INSTR_WIDTH = 14
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [13:0] instr_word,
   input wire logic instr_valid,
   input wire logic [1:0] ptr_in_prog_mem,
   output logic fetch_strobe,
   output logic [1:0] phase,
   output logic instr_start,
   output logic instr_done,
   output logic busy,
   output logic file_rd_strobe,
   output logic file_wr_strobe,
   output logic w_wr_strobe,
   output logic [13:0] instr_out,
   output decode_pkg::decode_t dec
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (INSTR_WIDTH != decode_pkg::INSTR_W) begin : g_width_check
      $error("instruction width must be 14");
   end
   if (decode_pkg::PHASES != 4) begin : g_phase_check
      $error("phase counter serves four phases only");
   end
   if (decode_pkg::FILE_W != 7) begin : g_file_check
      $error("file address operand must be 7 bits");
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // pure function of the word and the pointer targets (pm): unused operand bits never reach a compare
   function automatic decode_pkg::decode_t decode_fn(input logic [13:0] w, input logic [1:0] pm);
      decode_pkg::decode_t d;
      logic ind;
      d = '0;
      ind = 1'b0;
      d.cycles = decode_pkg::CYC_ONE;
      d.file_addr = w[decode_pkg::FILE_W-1:0];
      d.bit_sel = w[decode_pkg::BIT_HI:decode_pkg::BIT_LO];
      d.ptr_mode = decode_pkg::ptr_mode_t'(w[1:0]);
      case (w[decode_pkg::GRP_HI:decode_pkg::GRP_LO])
         decode_pkg::GRP_BYTE: begin
            d.cls = decode_pkg::CLS_BYTE;
            if (w[11:7] == decode_pkg::BOP_CTRL) begin
               d.cls = decode_pkg::CLS_LITCTL;
               if (w[13:4] == decode_pkg::IND_PREFIX) begin
                  d.ptr_used = 1'b1;
                  d.ptr_num = w[decode_pkg::PTR_N_IND];
                  d.mode_used = 1'b1;
                  d.file_store = w[decode_pkg::STORE_SEL];
                  d.w_store = !w[decode_pkg::STORE_SEL];
                  ind = 1'b1;
               end else if (w == decode_pkg::OP_CALL_W) begin
                  d.cycles = decode_pkg::CYC_TWO;
               end else if (w == decode_pkg::OP_RETURN || w == decode_pkg::OP_RETURN_INT) begin
                  d.cycles = decode_pkg::CYC_TWO;
               end else if (w == decode_pkg::OP_BRANCH_W) begin
                  d.cycles = decode_pkg::CYC_TWO;
               end
            end else if (w[11:8] == decode_pkg::BOP_CLR && !w[decode_pkg::D_BIT]) begin
               // clear of working register: low operand bits ignored
               d.w_store = 1'b1;
            end else begin
               d.file_op = 1'b1;
               d.file_store = w[decode_pkg::D_BIT];
               d.w_store = !w[decode_pkg::D_BIT];
               // skip forms take two cycles whether they skip or not (three through a program-memory pointer): no skip condition reaches this block
               if (w[11:8] == decode_pkg::BOP_DEC_SKIP || w[11:8] == decode_pkg::BOP_INC_SKIP) begin
                  d.cycles = decode_pkg::CYC_TWO;
               end
            end
         end
         decode_pkg::GRP_BIT: begin
            d.cls = decode_pkg::CLS_BIT;
            d.file_op = 1'b1;
            d.file_store = !w[11];
            if (w[11]) begin
               d.cycles = decode_pkg::CYC_TWO;
            end
         end
         default: begin
            d.cls = decode_pkg::CLS_LITCTL;
            if (w[13:11] == decode_pkg::LOP_CALL) begin
               d.cycles = decode_pkg::CYC_TWO;
            end else if (w[13:11] == decode_pkg::LOP_JUMP) begin
               d.cycles = decode_pkg::CYC_TWO;
            end else if (w[13:8] == decode_pkg::LOP_RETLIT) begin
               d.cycles = decode_pkg::CYC_TWO;
               d.w_store = 1'b1;
            end else if (w[13:9] == decode_pkg::LOP_BRANCH_REL) begin
               d.cycles = decode_pkg::CYC_TWO;
            end else if (w[13:7] == decode_pkg::LOP_IND_RD || w[13:7] == decode_pkg::LOP_IND_WR) begin
               d.ptr_used = 1'b1;
               d.ptr_num = w[decode_pkg::PTR_N_OFS];
               d.file_store = w[7];
               d.w_store = !w[7];
               ind = 1'b1;
            end else begin
               d.w_store = 1'b1;
            end
         end
      endcase
      // a file operand at either indirect-access address goes through a pointer
      if (d.file_op && w[6:1] == decode_pkg::IND_FILE_HI) begin
         d.ptr_used = 1'b1;
         d.ptr_num = w[0];
         ind = 1'b1;
      end
      // pointer target is sampled with the word: a pointer moved just before must settle first
      if (ind && pm[d.ptr_num]) begin
         d.cycles = d.cycles + decode_pkg::CYC_EXTRA;
      end
      return d;
   endfunction

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // 2-bit wrap-around step shared by the phase and cycle counters
   function automatic logic [1:0] step_fn(input logic [1:0] v);
      return v + 2'h1;
   endfunction

   // one place for loading a word, shared by the idle and back-to-back paths
   function automatic decode_pkg::core_state_t load_fn(input decode_pkg::core_state_t s, input logic [13:0] w,
         input logic [1:0] pm);
      decode_pkg::core_state_t n;
      n = s;
      n.seq = decode_pkg::SEQ_EXEC;
      n.cyc = decode_pkg::CYC_RST;
      n.instr = w;
      n.dec = decode_fn(w, pm);
      return n;
   endfunction

   // ----------------------------------------------------------------
   // sequencer state
   // ----------------------------------------------------------------
   decode_pkg::core_state_t st_r;
   decode_pkg::core_state_t st_nxt;
   logic phase_end;
   logic last_cycle;
   logic instr_end;

   assign phase_end = (st_r.phase == decode_pkg::PHASE_LAST);
   assign last_cycle = (st_r.cyc == st_r.dec.cycles - decode_pkg::CYC_ONE);
   assign instr_end = (st_r.seq == decode_pkg::SEQ_EXEC) && phase_end && last_cycle;

   always_comb begin
      st_nxt = st_r;
      st_nxt.phase = step_fn(st_r.phase);
      case (st_r.seq)
         decode_pkg::SEQ_IDLE: begin
            if (phase_end && instr_valid) begin
               st_nxt = load_fn(st_nxt, instr_word, ptr_in_prog_mem);
            end
         end
         decode_pkg::SEQ_EXEC: begin
            if (phase_end) begin
               if (!last_cycle) begin
                  st_nxt.cyc = step_fn(st_r.cyc);
               end else if (instr_valid) begin
                  // back-to-back words: next decode starts with no gap
                  st_nxt = load_fn(st_nxt, instr_word, ptr_in_prog_mem);
               end else begin
                  st_nxt.seq = decode_pkg::SEQ_IDLE;
               end
            end
         end
         default: begin
            st_nxt.seq = decode_pkg::SEQ_IDLE;
         end
      endcase
   end

   // reset loads constants only, so the phase restarts cleanly mid-instruction
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r.seq <= decode_pkg::SEQ_IDLE;
         st_r.phase <= decode_pkg::PHASE_RST;
         st_r.cyc <= decode_pkg::CYC_RST;
         st_r.instr <= decode_pkg::INSTR_RST;
         st_r.dec <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // fetch overlaps the last phase so a new word can start on the next cycle
   assign fetch_strobe = phase_end && ((st_r.seq == decode_pkg::SEQ_IDLE) || last_cycle);
   assign busy = (st_r.seq == decode_pkg::SEQ_EXEC);
   assign instr_start = busy && (st_r.phase == decode_pkg::PHASE_RST) && (st_r.cyc == decode_pkg::CYC_RST);
   assign instr_done = instr_end;
   // read at the first phase, store at the last: read precedes write where both occur; pointer-form stores strobe no read
   assign file_rd_strobe = instr_start && st_r.dec.file_op;
   assign file_wr_strobe = instr_end && st_r.dec.file_store;
   assign w_wr_strobe = instr_end && st_r.dec.w_store;
   assign phase = st_r.phase;
   assign instr_out = st_r.instr;
   assign dec = st_r.dec;

endmodule

// ===== verification/prog_mem_model.sv
/* program memory model feeding instruction words to the decode block.
   assumes the bench drives req_* off the falling edge. */
`timescale 1ns/100ps
module prog_mem_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic fetch_strobe,
   input wire logic [13:0] req_word,
   input wire logic [1:0] req_ptr,
   input wire logic req_valid,
   input wire logic stall,
   output logic [13:0] instr_word,
   output logic instr_valid,
   output logic [1:0] ptr_in_prog_mem
);
   // ----------------------------------------
   // word delivery
   // ----------------------------------------
   logic [15:0] last_r;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_r <= 16'h0000;
      end else if (fetch_strobe && instr_valid) begin
         last_r <= {ptr_in_prog_mem, instr_word};
      end
   end
   // stall models a slow memory; released lines show the inverse, not the old word
   assign instr_valid = req_valid && !stall;
   assign instr_word = instr_valid ? req_word : ~last_r[13:0];
   assign ptr_in_prog_mem = instr_valid ? req_ptr : ~last_r[15:14];
endmodule

// ===== verification/instr_cycle_decode_chk.sv
/* port-level assertions for the decode block.
   assumes a single core_clk domain, sys_rst async active high. */
`timescale 1ns/100ps
module instr_cycle_decode_chk (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [13:0] instr_word,
   input wire logic instr_valid,
   input wire logic [1:0] ptr_in_prog_mem,
   input wire logic fetch_strobe,
   input wire logic [1:0] phase,
   input wire logic instr_start,
   input wire logic instr_done,
   input wire logic busy,
   input wire logic file_rd_strobe,
   input wire logic file_wr_strobe,
   input wire logic w_wr_strobe,
   input wire logic [13:0] instr_out,
   input wire decode_pkg::decode_t dec
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_phase_step: assert property (1 |=> phase == $past(phase) + 2'h1)
      else $error("phase did not advance by one");
   a_fetch_last: assert property (fetch_strobe |-> phase == 2'h3)
      else $error("fetch outside last phase");
   a_one_cycle: assert property (instr_start && dec.cycles == 2'h1 |-> (!instr_done)[*3] ##1 instr_done)
      else $error("one-cycle length wrong");
   a_two_cycle: assert property (instr_start && dec.cycles == 2'h2 |-> ##7 instr_done)
      else $error("two-cycle length wrong");
   a_three_cycle: assert property (instr_start && dec.cycles == 2'h3 |-> ##11 instr_done)
      else $error("three-cycle length wrong");
   a_read_first: assert property (instr_start && dec.file_store |-> file_rd_strobe)
      else $error("file store without prior read");
   a_store_late: assert property (file_wr_strobe || w_wr_strobe |-> instr_done && phase == 2'h3)
      else $error("store strobe outside last phase");
   a_dest_sel: assert property (instr_start && instr_out[13:12] == 2'h0 && instr_out[13:4] != 10'h001
      && (dec.file_store || dec.w_store) |-> dec.file_store == instr_out[7] && dec.w_store != instr_out[7])
      else $error("destination select wrong");
   a_bit_fields: assert property (instr_start && instr_out[13:12] == 2'h1 |->
      dec.bit_sel == instr_out[9:7] && dec.file_addr == instr_out[6:0] && dec.cls == decode_pkg::CLS_BIT)
      else $error("bit operand fields wrong");
   a_litctl_class: assert property (instr_start && instr_out[13] |-> dec.cls == decode_pkg::CLS_LITCTL)
      else $error("literal class wrong");
   a_ptr_mode: assert property (instr_start && dec.mode_used |->
      dec.ptr_num == instr_out[2] && dec.ptr_mode == instr_out[1:0])
      else $error("pointer number or mode wrong");
   c_one: cover property (instr_start && dec.cycles == 2'h1);
   c_two: cover property (instr_start && dec.cycles == 2'h2);
   c_three: cover property (instr_start && dec.cycles == 2'h3);
endmodule
bind instr_cycle_decode instr_cycle_decode_chk chk_u (.core_clk, .sys_rst, .instr_word, .instr_valid,
   .ptr_in_prog_mem, .fetch_strobe, .phase, .instr_start, .instr_done, .busy, .file_rd_strobe, .file_wr_strobe,
   .w_wr_strobe, .instr_out, .dec);

// ===== verification/instr_cycle_decode_tb.sv
/* self-checking bench for the decode block.
   assumes prog_mem_model and the bound checker are compiled first. */
`timescale 1ns/100ps
module instr_cycle_decode_tb;
   // ----------------------------------------
   // wiring
   // ----------------------------------------
   logic core_clk, sys_rst, req_valid, stall, instr_valid, fetch_strobe, instr_start, instr_done, busy;
   logic file_rd_strobe, file_wr_strobe, w_wr_strobe, seen_rd, seen_wr, seen_w;
   logic [13:0] req_word, instr_word, instr_out;
   logic [1:0] req_ptr, ptr_in_prog_mem, phase;
   decode_pkg::decode_t dec, seen_dec;
   int seen_len, num_errors, compares;
   prog_mem_model mem_u (.core_clk, .sys_rst, .fetch_strobe, .req_word, .req_ptr, .req_valid, .stall, .instr_word,
      .instr_valid, .ptr_in_prog_mem);
   instr_cycle_decode #(.INSTR_WIDTH(14)) dut_u (.core_clk, .sys_rst, .instr_word, .instr_valid, .ptr_in_prog_mem,
      .fetch_strobe, .phase, .instr_start, .instr_done, .busy, .file_rd_strobe, .file_wr_strobe, .w_wr_strobe,
      .instr_out, .dec);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic finish_test();
      if (num_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   // waits are bounded; a hang counts as a mismatch
   task automatic run(input logic [13:0] word, input logic [1:0] ptr);
      int n;
      req_word = word;
      req_ptr = ptr;
      req_valid = 1'b1;
      n = 0;
      while (instr_start !== 1'b1) begin
         @(negedge core_clk);
         n++;
         if (n > 40) begin
            num_errors++;
            finish_test();
         end
      end
      req_valid = 1'b0;
      seen_rd = file_rd_strobe;
      seen_dec = dec;
      check_val("start phase", 16'h0000, {14'h0000, phase});
      seen_len = 1;
      while (instr_done !== 1'b1) begin
         @(negedge core_clk);
         seen_len++;
         if (seen_len > 20) begin
            num_errors++;
            finish_test();
         end
      end
      seen_wr = file_wr_strobe;
      seen_w = w_wr_strobe;
   endtask
   task automatic expect_op(input logic [13:0] word, input logic [1:0] ptr, input int cyc, input logic [2:0] rww);
      run(word, ptr);
      check_val("length", 16'(4 * cyc), 16'(seen_len));
      check_val("strobes", {13'h0000, rww}, {13'h0000, seen_rd, seen_wr, seen_w});
      check_val("word", {2'h0, word}, {2'h0, instr_out});
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic scen_fields();
      expect_op(14'h07a0, 2'h0, 1, 3'b110);
      expect_op(14'h0720, 2'h0, 1, 3'b101);
      check_val("class", 16'h0000, {14'h0000, seen_dec.cls});
      expect_op(14'h16a1, 2'h0, 1, 3'b110);
      check_val("bit", 16'h0005, {13'h0000, seen_dec.bit_sel});
      expect_op(14'h07ff, 2'h0, 1, 3'b110);
      check_val("file", 16'h007f, {9'h000, seen_dec.file_addr});
   endtask
   task automatic scen_branches();
      logic [13:0] w [8] = '{14'h0008, 14'h0009, 14'h000a, 14'h000b, 14'h2123, 14'h2845, 14'h3455, 14'h3205};
      for (int i = 0; i < 8; i++) begin
         run(w[i], 2'h0);
         check_val("branch length", 16'h0008, 16'(seen_len));
      end
      expect_op(14'h19a2, 2'h0, 2, 3'b100);
      expect_op(14'h1da2, 2'h0, 2, 3'b100);
      expect_op(14'h0ba3, 2'h0, 2, 3'b110);
      expect_op(14'h0f23, 2'h0, 2, 3'b101);
   endtask
   task automatic scen_indirect();
      expect_op(14'h0801, 2'h2, 2, 3'b101);
      expect_op(14'h0801, 2'h1, 1, 3'b101);
      expect_op(14'h0880, 2'h1, 2, 3'b110);
      expect_op(14'h0b80, 2'h1, 3, 3'b110);
      for (int i = 0; i < 8; i++) begin
         run(14'h0010 | 14'(i), 2'h0);
         check_val("mode", 16'(i), {13'h0000, seen_dec.ptr_num, seen_dec.ptr_mode});
         check_val("ptr used", 16'h0001, {15'h0000, seen_dec.ptr_used});
      end
   endtask
   task automatic scen_dont_care();
      logic [3:0] first;
      expect_op(14'h0100, 2'h0, 1, 3'b001);
      first = {seen_len[1:0] == 2'h0, seen_rd, seen_wr, seen_w};
      expect_op(14'h017f, 2'h0, 1, 3'b001);
      check_val("dont care", {12'h000, first}, {12'h000, seen_len[1:0] == 2'h0, seen_rd, seen_wr, seen_w});
   endtask
   task automatic scen_reset();
      req_word = 14'h2123;
      req_valid = 1'b1;
      repeat (6) @(negedge core_clk);
      check_val("busy", 16'h0001, {15'h0000, busy});
      sys_rst = 1'b1;
      stall = 1'b1;
      @(negedge core_clk);
      check_val("reset state", 16'h0000, {busy, phase, instr_out[12:0]});
      sys_rst = 1'b0;
      for (int i = 1; i < 7; i++) begin
         @(negedge core_clk);
         check_val("phase idle", 16'(i % 4), {busy, 13'h0000, phase});
      end
      stall = 1'b0;
      req_valid = 1'b0;
   endtask
   // ----------------------------------------
   // main
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      sys_rst = 1'b1;
      req_valid = 1'b0;
      stall = 1'b0;
      req_word = 14'h0000;
      req_ptr = 2'h0;
      num_errors = 0;
      compares = 0;
      repeat (4) @(negedge core_clk);
      sys_rst = 1'b0;
      scen_fields();
      scen_branches();
      scen_indirect();
      scen_dont_care();
      scen_reset();
      finish_test();
   end
endmodule
